// ==== rtl/dke_cfg.svh ====
// Constants for the decimal key encoder and debouncer
// Assumes inclusion by rtl files after the package, by bare name
`ifndef DKE_CFG_SVH
`define DKE_CFG_SVH
`define DKE_CODE_W        4
`define DKE_SYNC_STAGES   2
`define DKE_DEB_STAGES    2
`define DKE_DIV_DEFAULT   16'h00FF
`define DKE_DIV_W         16
`define DKE_CODE_RESET    4'h0
`endif

// ==== rtl/dke_pkg.sv ====
// Types for the decimal key encoder and debouncer
// Assumes no surroundings; holds types only
package dke_pkg;
   typedef logic [3:0] dke_bcd_t;
   typedef struct packed
   {
      logic     tens;
      logic     any_active_flag;
      dke_bcd_t units;
   } dke_code_t;
   typedef struct packed
   {
      logic [7:0] linear_n;
      logic       cascade_enable_out;
   } dke_lin_t;
endpackage : dke_pkg

// ==== rtl/dke_encoder.sv ====
// Decimal key encoder with clocked debouncer and linear priority output
// Assumes keys are active LOW and sys_clk runs at 100 MHz
//
// What this block does
// - Keys eight or nine disable priority stage
// - Ten-line encoder gives highest key BCD
// - Active-LOW option inverts bits zero, three
// - Upper flag drives tens, selects units
// - Every bit shifts through two-stage chain
// - Valid at the tick after two matches
// - Valid never high while code changes
// - Linear mode: one-hot low, highest input
// - Highest of eight lines wins
// - Any-active flag high when line active
// - Enable high forces linear outputs high
`timescale 1ns/1ps
`include "dke_cfg.svh"
module dke_encoder
(
   // Clock and reset
   input  wire  logic                 sys_clk,
   input  wire  logic                 rst_n,
   // Keys, active LOW: lower decade then upper decade
   input  wire  logic [19:0]          key_n,
   input  wire  logic                 cascade_enable_in,
   // Configuration
   input  wire  logic                 active_low_sel,
   input  wire  logic [15:0]          sample_div,
   // Outputs
   output dke_pkg::dke_code_t         code,
   output logic                       code_valid,
   output dke_pkg::dke_lin_t          lin
);
   import dke_pkg::*;

   // --------------------------------------------------------------
   // Synchronizer
   // --------------------------------------------------------------
   logic [19:0] sync1_ff;
   logic [19:0] sync2_ff;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_ff <= 20'hF_FFFF;
         sync2_ff <= 20'hF_FFFF;
      end
      else
      begin
         sync1_ff <= key_n;
         sync2_ff <= sync1_ff;
      end
   end

   // --------------------------------------------------------------
   // Eight-line priority stage, returns {flag_n, eo_n, addr_n[2:0]}
   // --------------------------------------------------------------
   function automatic logic [4:0] prio8(input logic [7:0] in_n, input logic ei_n);
      logic [2:0] a;
      logic       hit;
      // No active line leaves the address at zero, so an idle decade reads 0
      a   = 3'h0;
      hit = 1'b0;
      if (ei_n)
         return 5'h1F;
      for (int i = 0; i < 8; i++)
      begin
         if (!in_n[i])
         begin
            a   = 3'(i);
            hit = 1'b1;
         end
      end
      return {~hit, hit, ~a};
   endfunction : prio8

   // Decade encoder: BCD of highest active key, plus active flag
   function automatic logic [4:0] dec10(input logic [9:0] in_n);
      logic [4:0] p;
      logic       top;
      top = ~(in_n[8] & in_n[9]);
      p   = prio8(in_n[7:0], top);
      if (top)
         return {1'b1, 3'h4, ~in_n[9]};
      return {~p[4], 1'b0, ~p[2:0]};
   endfunction : dec10

   // --------------------------------------------------------------
   // Twenty-line combination
   // --------------------------------------------------------------
   logic [4:0] lo_dec;
   logic [4:0] hi_dec;
   logic [3:0] units_hi;
   logic [3:0] units_raw;
   logic [5:0] enc_now;
   assign lo_dec    = dec10(sync2_ff[9:0]);
   assign hi_dec    = dec10(sync2_ff[19:10]);
   assign units_hi  = hi_dec[4] ? hi_dec[3:0] : lo_dec[3:0];
   assign units_raw = active_low_sel ? {~units_hi[3], units_hi[2:1], ~units_hi[0]}
                                     : units_hi;
   assign enc_now   = {hi_dec[4], hi_dec[4] | lo_dec[4], units_raw};

   // --------------------------------------------------------------
   // Sample rate divider
   // --------------------------------------------------------------
   logic [`DKE_DIV_W-1:0] div_ff;
   logic                  tick;
   // Raise sample_div only while running: a value below the running count
   // makes the counter wrap through its full range before the next tick
   assign tick = (div_ff == sample_div);
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         div_ff <= '0;
      else
         div_ff <= tick ? '0 : div_ff + 16'h0001;
   end

   // --------------------------------------------------------------
   // Debounce chains, one per code bit
   // --------------------------------------------------------------
   logic [5:0] st0_ff;
   logic [5:0] st1_ff;
   logic [5:0] match;
   genvar g;
   generate
      for (g = 0; g < 6; g++)
      begin : g_chain
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               st0_ff[g] <= 1'b0;
               st1_ff[g] <= 1'b1;
            end
            else if (tick)
            begin
               st0_ff[g] <= enc_now[g];
               st1_ff[g] <= st0_ff[g];
            end
         end
         assign match[g] = (st0_ff[g] == st1_ff[g]);
      end
   endgenerate

   // --------------------------------------------------------------
   // Change watch between ticks
   // --------------------------------------------------------------
   // Contacts that chatter in step with the tick alias into matching
   // samples; any change seen between two ticks blocks the next set.
   // At a tick the newest code is taken into st0, so the clear wins there.
   logic moved_now;
   logic moved_ff;
   assign moved_now = (st0_ff != enc_now);
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         moved_ff <= 1'b0;
      else if (tick)
         moved_ff <= 1'b0;
      else if (moved_now)
         moved_ff <= 1'b1;
   end

   // --------------------------------------------------------------
   // Valid flag and presented code
   // --------------------------------------------------------------
   logic       valid_ff;
   logic [5:0] code_ff;
   logic [1:0] fill_ff;
   logic       agree;
   logic       set_ok;
   assign agree  = (&match) && (st0_ff == enc_now);
   // A set needs both stages refilled since reset and a quiet interval
   assign set_ok = agree && !moved_ff && fill_ff[1];
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         valid_ff <= 1'b0;
         code_ff  <= 6'h00;
         fill_ff  <= 2'h0;
      end
      else
      begin
         if (tick)
            valid_ff <= set_ok;
         else if (!agree)
            valid_ff <= 1'b0;
         if (tick)
            code_ff <= st1_ff;
         if (tick)
            fill_ff <= {fill_ff[0], 1'b1};
      end
   end
   assign code       = dke_code_t'(code_ff);
   assign code_valid = valid_ff && (code_ff == st1_ff) && agree;

   // --------------------------------------------------------------
   // Linear priority output over lines zero to seven
   // --------------------------------------------------------------
   logic [4:0] lin_p;
   logic [7:0] lin_ff;
   logic       eo_ff;
   assign lin_p = prio8(sync2_ff[7:0], cascade_enable_in);
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lin_ff <= 8'hFF;
         eo_ff  <= 1'b1;
      end
      else
      begin
         lin_ff <= lin_p[4] ? 8'hFF : ~(8'h01 << (~lin_p[2:0]));
         eo_ff  <= lin_p[3];
      end
   end
   assign lin.linear_n           = lin_ff;
   assign lin.cascade_enable_out = eo_ff;
endmodule : dke_encoder

// ==== testbench/dke_encoder_properties.sv ====
// Port checker for the key encoder, bound below
// Assumes sample_div of 3 while reset is released
`timescale 1ns/1ps
module dke_chk
(
   // Observed ports
   input wire logic     sys_clk,
   input wire logic     rst_n,
   input wire logic     cascade_enable_in,
   input wire logic     active_low_sel,
   input dke_pkg::dke_code_t code,
   input wire logic     code_valid,
   input dke_pkg::dke_lin_t  lin
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   chk_valid_hold: assert property (code_valid && $past(code_valid) |-> $stable(code))
      else $error("code moved");
   chk_tens_flag: assert property (code.tens |-> code.any_active_flag) else $error("tens");
   chk_units_bcd: assert property (code_valid && !active_low_sel |-> code.units <= 4'h9)
      else $error("units");
   chk_lin_onehot: assert property ($countones(~lin.linear_n) <= 1) else $error("lin");
   chk_eo_idle: assert property (!lin.cascade_enable_out |-> &lin.linear_n) else $error("eo");
   chk_disable_high: assert property (cascade_enable_in [*4] |=> &lin.linear_n)
      else $error("disable");
   chk_reset_quiet: assert property ($rose(rst_n) |-> !code_valid [*6]) else $error("rst");
   chk_idle_zero: assert property (code_valid && !code.any_active_flag && !active_low_sel
      |-> code.units == 4'h0 && !code.tens) else $error("idle");
   cover property ($rose(code_valid));
   cover property (code_valid && code.tens);
   cover property (code_valid && active_low_sel);
endmodule : dke_chk
bind dke_encoder dke_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .code(code), .lin(lin),
   .cascade_enable_in(cascade_enable_in), .active_low_sel(active_low_sel),
   .code_valid(code_valid));

// ==== testbench/dke_keypad.sv ====
// Keypad model: contacts settle to want_n or chatter
// Assumes the bench drives want_n and chatter
`timescale 1ns/1ps
module dke_keypad
(
   input  wire logic        sys_clk,
   input  wire logic [19:0] want_n,
   input  wire logic        chatter,
   output logic      [19:0] key_n
);
   initial key_n = 20'hF_FFFF;
   // Chattering contacts flip every clock
   always @(posedge sys_clk) key_n <= chatter ? ~key_n : want_n;
endmodule : dke_keypad

// ==== testbench/dke_encoder_tb.sv ====
// Bench for the key encoder, one task per scenario
// Assumes the keypad model drives the keys
`timescale 1ns/1ps
module dke_encoder_tb;
   import dke_pkg::*;
   logic sys_clk = 0, rst_n = 0, cascade_enable_in = 0, active_low_sel = 0, chatter = 0;
   logic [19:0] want_n = '1, key_n;
   logic [15:0] sample_div = 16'h0003;
   dke_code_t code;
   dke_lin_t lin;
   logic code_valid;
   int n_errors = 0, check_count = 0;
   initial forever #5 sys_clk = ~sys_clk;
   dke_keypad u_pad (.sys_clk(sys_clk), .want_n(want_n), .chatter(chatter), .key_n(key_n));
   dke_encoder DUT (.sys_clk(sys_clk), .rst_n(rst_n), .key_n(key_n), .lin(lin),
      .cascade_enable_in(cascade_enable_in), .active_low_sel(active_low_sel),
      .sample_div(sample_div), .code(code), .code_valid(code_valid));
   task summarize;
      if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   task cmp(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask : cmp
   task press(input logic [19:0] v);
      int i;
      @(posedge sys_clk) want_n <= v;
      repeat (5) @(negedge sys_clk);
      for (i = 0; i < 40 && code_valid !== 1'b1; i++) @(negedge sys_clk);
      if (i == 40)
      begin
         n_errors++;
         $display("ERROR %0t no valid code", $time);
         summarize();
      end
   endtask : press
   task t_decade;
      for (int k = 0; k < 10; k++)
      begin
         press(~(20'h0_0001 << k));
         cmp({2'b00, code}, {4'b0001, 4'(k)});
         if (k < 8) cmp(lin.linear_n, ~(8'h01 << k));
      end
      press(20'hF_FEF7);
      cmp({2'b00, code}, 8'h18);
      press(20'hF_FF5B);
      cmp({2'b00, code}, 8'h17);
      cmp(lin.linear_n, 8'h7F);
   endtask : t_decade
   task t_twenty;
      press(20'hF_7F7F);
      cmp({2'b00, code}, 8'h35);
      @(posedge sys_clk) active_low_sel <= 1'b1;
      press(20'hF_FFFB);
      cmp({2'b00, code}, 8'h1B);
   endtask : t_twenty
   task t_linear;
      @(posedge sys_clk) active_low_sel <= 1'b0;
      cascade_enable_in <= 1'b1;
      press(20'hF_FFBB);
      cmp(lin.linear_n, 8'hFF);
      @(posedge sys_clk) cascade_enable_in <= 1'b0;
      press(20'hF_FFFF);
      cmp({1'b0, lin.cascade_enable_out, code}, 8'h00);
   endtask : t_linear
   task t_chatter;
      press(20'hF_FFDF);
      @(posedge sys_clk) chatter <= 1'b1;
      repeat (3) @(negedge sys_clk);
      repeat (12)
      begin
         @(negedge sys_clk);
         cmp({7'd0, code_valid}, 8'h00);
      end
      @(posedge sys_clk) chatter <= 1'b0;
      press(20'hF_FFDF);
      cmp({2'b00, code}, 8'h15);
   endtask : t_chatter
   task t_reset;
      int n;
      @(posedge sys_clk) rst_n <= 1'b0;
      want_n <= '1;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(negedge sys_clk);
      cmp({1'b0, code_valid, code}, 8'h00);
      // Idle keys: valid only after three ticks of four clocks
      for (n = 0; n < 40 && code_valid !== 1'b1; n++) @(negedge sys_clk);
      cmp(8'(n), 8'h0C);
      if (n == 40) summarize();
      press(20'h7_FFFF);
      cmp({2'b00, code}, 8'h39);
   endtask : t_reset
   task t_rate;
      int n;
      @(posedge sys_clk) sample_div <= 16'h0007;
      want_n <= 20'hF_FFFD;
      repeat (5) @(negedge sys_clk);
      for (n = 0; n < 60 && code_valid !== 1'b1; n++) @(negedge sys_clk);
      // First tick five to eight clocks in, then two more eight apart
      cmp({7'd0, (n >= 17) && (n <= 20)}, 8'h01);
      cmp({2'b00, code}, 8'h11);
   endtask : t_rate
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_decade();
      t_twenty();
      t_linear();
      t_chatter();
      t_reset();
      t_rate();
      summarize();
   end
endmodule : dke_encoder_tb
